// ==== rtl/adc_channel_ctrl.sv ====
// Purpose: converter control register, source select decode and test pin routing
// Assumes: APB slave, zero wait states, 10 MHz clock
// Notes:   the converter and analog muxes sit outside; this block steers them
//
// Summary of operation
// R1: five-bit writable source select feeds converter and test buffer.
// R2: codes 00000..00111 pick the eight internal nodes in listed order.
// R3: 01000, 01001 reserved; 10001..10111 unimplemented; no defined signal.
// R4: codes 01010..10000 pick the seven further internal nodes in order.
// R5: codes 11000..11100 pick port A pins 0..3 then port B pin 1.
// R6: codes 11101..11111 pick port B pins 4..6, larger package only.
// R7: writing 1 to the flag starts a conversion; flag reads 1 meanwhile.
// R8: hardware clears the flag when the conversion completes.
// R9: flag reading 0 means idle or last conversion finished.
// R10: enable bit powers the converter; cleared means shut off.
// R11: top control bit always reads zero.
// R12: source select also chooses the test buffer signal.
// R13: buffered test signal reaches port A pin 0 under block enable register.
// R14: analog test enable clear sends signal to converter, set to pin.
// R15: digital test enable wins port A pin 0 over analog.
// R16: start with converter disabled does nothing and flag returns 0.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module adc_channel_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1,
    parameter int TIMEOUT       = CONV_TIMEOUT
) (
    input  wire  logic                CLOCK_IN,
    input  wire  logic                NRST_IN,
    input  wire  logic                PSEL_IN,
    input  wire  logic                PENABLE_IN,
    input  wire  logic                PWRITE_IN,
    input  wire  logic [7:0]          PADDR_IN,
    input  wire  logic [31:0]         PWDATA_IN,
    input  wire  logic                EOC_IN,
    input  wire  logic [RESULT_W-1:0] RESULT_IN,
    output logic [31:0]               PRDATA_OUT,
    output logic                      PREADY_OUT,
    output logic                      PSLVERR_OUT,
    output logic                      CONV_POWER_OUT,
    output logic                      CONV_SAMPLE_OUT,
    output logic [4:0]                SRC_SEL_OUT,
    output logic                      SRC_DEFINED_OUT,
    output logic                      SRC_EXTERNAL_OUT,
    output logic [2:0]                EXT_CHANNEL_OUT,
    output logic                      MUX_TO_CONV_OUT,
    output logic                      PA0_ANALOG_OUT,
    output logic                      PA0_DIGITAL_OUT
);
    if (TIMEOUT < 2 || TIMEOUT > 65535) begin : g_bad_timeout
        $error("TIMEOUT out of range");
    end

    localparam int SAMPLE_MAX = ACQ_CYCLES + 1;
    localparam int FLAG_MAX   = ACQ_CYCLES + TIMEOUT;

    conv_if cv ();

    logic [4:0]          src_reg;
    logic                go_reg;
    logic                on_reg;
    logic [7:0]          abe_reg;
    logic [RESULT_W-1:0] result_reg;
    logic                eoc_meta_reg;
    logic                eoc_sync_reg;
    logic                eoc_prev_reg;
    logic                setup;
    logic                wr;
    logic                wr_ctrl;
    logic                start_req;
    logic                go_next;
    logic                src_ok;
    logic                valid_addr;
    logic [7:0]          ctrl_rd;
    logic [16:0]         flag_age_reg;

    // ==========================================================
    // bus decode
    assign setup      = PSEL_IN && !PENABLE_IN;
    assign wr         = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
    assign wr_ctrl    = wr && PADDR_IN == CONV_CTRL_OFS;
    assign valid_addr = PADDR_IN == CONV_CTRL_OFS || PADDR_IN == ABE_OFS
                        || (PADDR_IN == RESULT_OFS && !PWRITE_IN);
    assign ctrl_rd    = {1'b0, src_reg, go_reg, on_reg}; // see R11, see R9

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h00000000;
        end else begin
            PREADY_OUT  <= setup;
            PSLVERR_OUT <= setup && !valid_addr;
            if (setup && !PWRITE_IN) begin
                unique case (PADDR_IN)
                    CONV_CTRL_OFS: PRDATA_OUT <= {24'h000000, ctrl_rd};
                    ABE_OFS:       PRDATA_OUT <= {24'h000000, abe_reg};
                    RESULT_OFS:    PRDATA_OUT <= {{(32-RESULT_W){1'b0}}, result_reg};
                    default:       PRDATA_OUT <= 32'h00000000;
                endcase
            end
        end
    end

    // ==========================================================
    // control register
    assign start_req = wr_ctrl && PWDATA_IN[CC_GO_BIT] && PWDATA_IN[CC_ON_BIT]; // see R7, see R16

    always_comb begin
        go_next = go_reg;
        if (start_req) begin
            go_next = 1'b1; // see R7
        end else if (wr_ctrl && !PWDATA_IN[CC_ON_BIT]) begin
            go_next = 1'b0; // see R16
        end else if (cv.done) begin
            go_next = 1'b0; // see R8
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            src_reg <= CONV_CTRL_RST[CC_SRC_MSB:CC_SRC_LSB];
            on_reg  <= CONV_CTRL_RST[CC_ON_BIT];
            go_reg  <= CONV_CTRL_RST[CC_GO_BIT];
        end else begin
            go_reg <= go_next;
            if (wr_ctrl) begin
                src_reg <= PWDATA_IN[CC_SRC_MSB:CC_SRC_LSB]; // see R1
                on_reg  <= PWDATA_IN[CC_ON_BIT]; // see R10
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            abe_reg <= ABE_RST;
        end else if (wr && PADDR_IN == ABE_OFS) begin
            abe_reg <= PWDATA_IN[7:0];
        end
    end

    // ==========================================================
    // end of conversion and result
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            eoc_meta_reg <= 1'b0;
            eoc_sync_reg <= 1'b0;
            eoc_prev_reg <= 1'b0;
        end else begin
            eoc_meta_reg <= EOC_IN;
            eoc_sync_reg <= eoc_meta_reg;
            eoc_prev_reg <= eoc_sync_reg;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            result_reg <= '0;
        end else if (cv.done) begin
            result_reg <= RESULT_IN;
        end
    end

    // ==========================================================
    // sequencer
    assign cv.start = start_req && !cv.busy; // see R7
    assign cv.abort = wr_ctrl && !PWDATA_IN[CC_ON_BIT];
    assign cv.eoc   = eoc_sync_reg && !eoc_prev_reg;

    conv_sequencer #(
        .ACQ     (ACQ_CYCLES),
        .TIMEOUT (TIMEOUT)
    ) u_seq (
        .clk  (CLOCK_IN),
        .nrst (NRST_IN),
        .cv   (cv.seq)
    );

    // ==========================================================
    // source decode and routing
    always_comb begin
        src_ok = 1'b1;
        if (src_reg == SRC_RSVD_LO || src_reg == SRC_RSVD_HI) begin
            src_ok = 1'b0; // see R3
        end else if (src_reg >= SRC_UNIMP_LO && src_reg <= SRC_UNIMP_HI) begin
            src_ok = 1'b0; // see R3
        end else if (src_reg >= SRC_PORT_B_PIN4 && !LARGE_PACKAGE) begin
            src_ok = 1'b0; // see R6
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CONV_POWER_OUT   <= 1'b0;
            CONV_SAMPLE_OUT  <= 1'b0;
            SRC_SEL_OUT      <= 5'h00;
            SRC_DEFINED_OUT  <= 1'b0;
            SRC_EXTERNAL_OUT <= 1'b0;
            EXT_CHANNEL_OUT  <= 3'h0;
        end else begin
            CONV_POWER_OUT   <= on_reg; // see R10
            CONV_SAMPLE_OUT  <= cv.sample;
            SRC_SEL_OUT      <= src_reg; // see R2, see R4, see R12
            SRC_DEFINED_OUT  <= src_ok; // see R3
            SRC_EXTERNAL_OUT <= src_ok && src_reg >= SRC_PORT_A_PIN0; // see R5, see R6
            EXT_CHANNEL_OUT  <= src_reg[2:0]; // see R5, see R6
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            MUX_TO_CONV_OUT <= 1'b1;
            PA0_ANALOG_OUT  <= 1'b0;
            PA0_DIGITAL_OUT <= 1'b0;
        end else begin
            MUX_TO_CONV_OUT <= !abe_reg[ABE_ANA_BIT]; // see R14
            PA0_ANALOG_OUT  <= abe_reg[ABE_ANA_BIT] && !abe_reg[ABE_DIG_BIT]; // see R13, see R15
            PA0_DIGITAL_OUT <= abe_reg[ABE_DIG_BIT]; // see R15
        end
    end

    // ==========================================================
    // age of the conversion flag, bounds the completion check
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            flag_age_reg <= 17'h00000;
        end else if (!go_reg || cv.done) begin
            flag_age_reg <= 17'h00000;
        end else begin
            flag_age_reg <= flag_age_reg + 17'h00001;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);

    a_start_sets_flag: assert property (start_req |=> go_reg) // see R7
        else $error("start did not set flag");
    a_done_clears_flag: assert property (cv.done && !start_req |=> !go_reg) // see R8
        else $error("flag not cleared at completion");
    a_flag_tracks_busy: assert property (go_reg && !cv.done |-> cv.busy) // see R9
        else $error("flag high while sequencer idle");
    a_off_no_start: assert property (wr_ctrl && !PWDATA_IN[CC_ON_BIT] |=> !go_reg && !cv.busy) // see R16
        else $error("start accepted while disabled");
    a_power_follows: assert property (1'b1 |=> CONV_POWER_OUT == $past(on_reg)) // see R10
        else $error("power output wrong");
    a_top_bit_zero: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == CONV_CTRL_OFS // see R11
                                      |-> PRDATA_OUT[7] == 1'b0)
        else $error("top bit read nonzero");
    a_reserved_undef: assert property (src_reg == SRC_RSVD_LO |=> !SRC_DEFINED_OUT) // see R3
        else $error("reserved code marked defined");
    a_ext_channel: assert property (src_reg == SRC_PORT_B_PIN1 |=> SRC_EXTERNAL_OUT // see R5
                                    && EXT_CHANNEL_OUT == 3'h4)
        else $error("port B pin 1 not channel 4");
    a_dig_priority: assert property (abe_reg[ABE_DIG_BIT] |=> !PA0_ANALOG_OUT && PA0_DIGITAL_OUT) // see R15
        else $error("analog drove pin over digital");
    a_conv_routing: assert property (!abe_reg[ABE_ANA_BIT] |=> MUX_TO_CONV_OUT && !PA0_ANALOG_OUT) // see R14
        else $error("test signal not routed to converter");
    a_sample_bound: assert property (cv.start |-> ##[1:SAMPLE_MAX] cv.sample or ##[1:SAMPLE_MAX] !cv.busy) // see R7
        else $error("acquisition overran");

    // source decode
    a_unimp_undef: assert property (src_reg inside {[SRC_UNIMP_LO:SRC_UNIMP_HI]} |=> !SRC_DEFINED_OUT) // see R3
        else $error("unimplemented code marked defined");

    a_lower_nodes: assert property (src_reg <= SRC_PEDESTAL |=> SRC_DEFINED_OUT && !SRC_EXTERNAL_OUT) // see R2
        else $error("internal node code decoded wrong");

    a_upper_nodes: assert property (src_reg inside {[SRC_ADJ_PRI:SRC_ERR_OR]} |=> SRC_DEFINED_OUT) // see R4
        else $error("further node code decoded wrong");

    a_port_pins: assert property (src_reg inside {[SRC_PORT_A_PIN0:SRC_PORT_B_PIN1]} // see R5
                                  |=> SRC_EXTERNAL_OUT && EXT_CHANNEL_OUT == $past(src_reg[2:0]))
        else $error("port pin code decoded wrong");

    a_wide_pins: assert property (src_reg >= SRC_PORT_B_PIN4 |=> SRC_EXTERNAL_OUT == LARGE_PACKAGE) // see R6
        else $error("wide package pin decoded wrong");

    a_select_write: assert property (wr_ctrl |=> src_reg == $past(PWDATA_IN[CC_SRC_MSB:CC_SRC_LSB])) // see R1
        else $error("source select not written");

    a_select_mirror: assert property (1'b1 |=> SRC_SEL_OUT == $past(src_reg)) // see R12
        else $error("test buffer select wrong");

    // pin routing
    a_analog_to_pin: assert property (abe_reg[ABE_ANA_BIT] && !abe_reg[ABE_DIG_BIT] |=> PA0_ANALOG_OUT) // see R13
        else $error("analog test signal not on pin");

    a_pin_released: assert property (abe_reg[ABE_ANA_BIT] |=> !MUX_TO_CONV_OUT) // see R14
        else $error("converter kept test signal");

    a_enable_write: assert property (wr && PADDR_IN == ABE_OFS |=> abe_reg == $past(PWDATA_IN[7:0])) // see R13
        else $error("block enable not written");

    // conversion flag
    a_busy_has_flag: assert property (cv.busy |-> go_reg) // see R7
        else $error("conversion running with flag clear");

    a_zero_keeps: assert property (go_reg && !cv.done && wr_ctrl && PWDATA_IN[CC_ON_BIT] |=> go_reg) // see R7
        else $error("write cleared a running flag");

    a_done_needs_flag: assert property (cv.done |-> go_reg) // see R8
        else $error("completion without a running flag");

    a_timeout_done: assert property (cv.timeout |-> cv.done) // see R8
        else $error("timeout did not complete");

    a_flag_bounded: assert property (go_reg |-> flag_age_reg <= 17'(FLAG_MAX)) // see R8
        else $error("flag outlived the conversion timeout");

    a_off_idle: assert property (!on_reg |-> !cv.busy) // see R10
        else $error("conversion running while disabled");

    a_abort_quiet: assert property (cv.abort |=> !cv.busy && !cv.sample && !cv.done) // see R16
        else $error("disabled converter kept converting");

    a_result_capture: assert property (cv.done |=> result_reg == $past(RESULT_IN))
        else $error("result not captured");

    // bus
    a_ready_setup: assert property (setup |=> PREADY_OUT)
        else $error("no answer after setup");

    a_error_unmapped: assert property (setup && !valid_addr |=> PSLVERR_OUT)
        else $error("unmapped access not refused");


    c_full_conversion: cover property (start_req ##[1:200] cv.done);
    c_restart_on_done: cover property (cv.done && start_req);
    c_timeout_end: cover property (cv.timeout);
    c_pin_analog: cover property (PA0_ANALOG_OUT);
    c_busy_restart: cover property (start_req && cv.busy);
endmodule

// ==== rtl/adc_ctrl_pkg.sv ====
// Purpose: shared constants for the converter control and test mux block
// Assumes: 32-bit APB, 10 MHz system clock
// Notes:   all offsets are byte addresses
package adc_ctrl_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] CONV_CTRL_OFS  = 8'h00;
    localparam logic [7:0] ABE_OFS        = 8'h04;
    localparam logic [7:0] RESULT_OFS     = 8'h08;
    localparam logic [7:0] CONV_CTRL_RST  = 8'h00;
    localparam logic [7:0] ABE_RST        = 8'h00;
    // ==========================================================
    // converter_control fields
    localparam int CC_ON_BIT   = 0;
    localparam int CC_GO_BIT   = 1;
    localparam int CC_SRC_LSB  = 2;
    localparam int CC_SRC_MSB  = 6;
    // analog_block_enable_reg fields
    localparam int ABE_ANA_BIT = 0;
    localparam int ABE_DIG_BIT = 7;
    // ==========================================================
    // source codes
    localparam logic [4:0] SRC_VIN_DIV     = 5'h00;
    localparam logic [4:0] SRC_PEDESTAL    = 5'h07;
    localparam logic [4:0] SRC_RSVD_LO     = 5'h08;
    localparam logic [4:0] SRC_RSVD_HI     = 5'h09;
    localparam logic [4:0] SRC_ADJ_PRI     = 5'h0A;
    localparam logic [4:0] SRC_ERR_OR      = 5'h10;
    localparam logic [4:0] SRC_UNIMP_LO    = 5'h11;
    localparam logic [4:0] SRC_UNIMP_HI    = 5'h17;
    localparam logic [4:0] SRC_PORT_A_PIN0 = 5'h18;
    localparam logic [4:0] SRC_PORT_B_PIN1 = 5'h1C;
    localparam logic [4:0] SRC_PORT_B_PIN4 = 5'h1D;
    localparam logic [4:0] SRC_PORT_B_PIN6 = 5'h1F;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int ACQ_TIME_NS    = 2000;
    localparam int ACQ_CYCLES     = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_TIMEOUT   = 1024;
    localparam int RESULT_W       = 10;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ACQUIRE, SEQ_CONVERT} seq_state_t;
endpackage

// ==== rtl/conv_if.sv ====
// Purpose: link between register logic and conversion sequencer
// Assumes: single clock domain
// Notes:   eoc arrives already synchronised
`timescale 1ns/1ps
interface conv_if;
    import adc_ctrl_pkg::*;
    logic                start;
    logic                abort;
    logic                eoc;
    logic                busy;
    logic                done;
    logic                sample;
    logic                timeout;
    modport ctrl (output start, output abort, output eoc, input busy, input done, input sample,
                  input timeout);
    modport seq  (input start, input abort, input eoc, output busy, output done, output sample,
                  output timeout);
endinterface

// ==== rtl/conv_sequencer.sv ====
// Purpose: paces one conversion: acquisition, start pulse, wait for end
// Assumes: eoc synchronised by the caller
// Notes:   a lost end of conversion is ended by a timeout
`timescale 1ns/1ps
module conv_sequencer
    import adc_ctrl_pkg::*;
#(
    parameter int ACQ     = ACQ_CYCLES,
    parameter int TIMEOUT = CONV_TIMEOUT
) (
    input  wire logic clk,
    input  wire logic nrst,
    conv_if.seq       cv
);
    if (ACQ < 1 || ACQ > 65536 || TIMEOUT < 2 || TIMEOUT > 65535) begin : g_bad_timing
        $error("bad sequencer timing");
    end

    seq_state_t  state_reg;
    logic [15:0] cnt_reg;

    // ==========================================================
    // state and counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= SEQ_IDLE;
            cnt_reg   <= 16'h0000;
        end else if (cv.abort) begin
            state_reg <= SEQ_IDLE;
            cnt_reg   <= 16'h0000;
        end else begin
            unique case (state_reg)
                SEQ_IDLE: begin
                    cnt_reg <= 16'h0000;
                    if (cv.start) begin
                        state_reg <= SEQ_ACQUIRE;
                    end
                end
                SEQ_ACQUIRE: begin
                    if (cnt_reg == 16'(ACQ - 1)) begin
                        state_reg <= SEQ_CONVERT;
                        cnt_reg   <= 16'h0000;
                    end else begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                SEQ_CONVERT: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cv.eoc || cnt_reg == 16'(TIMEOUT - 1)) begin
                        state_reg <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cv.done    <= 1'b0;
            cv.sample  <= 1'b0;
            cv.timeout <= 1'b0;
        end else begin
            cv.done    <= !cv.abort && state_reg == SEQ_CONVERT && (cv.eoc || cnt_reg == 16'(TIMEOUT - 1));
            cv.timeout <= !cv.abort && state_reg == SEQ_CONVERT && !cv.eoc && cnt_reg == 16'(TIMEOUT - 1);
            cv.sample  <= !cv.abort && state_reg == SEQ_ACQUIRE && cnt_reg == 16'(ACQ - 1);
        end
    end

    assign cv.busy = state_reg != SEQ_IDLE;
endmodule

// ==== tb/adc_channel_and_test_mux_control_tb.sv ====
// Purpose: self-checking bench for the converter control and test mux block
// Assumes: zero-wait APB slave, conversion timeout shortened to 16 cycles
// Notes:   random source codes and results come from a fixed-seed lfsr
`timescale 1ns/1ps
module adc_channel_and_test_mux_control_tb;
    import adc_ctrl_pkg::*;
    logic                clock = 1'b0;
    logic                nrst = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h00000000;
    logic                eoc = 1'b0;
    logic [RESULT_W-1:0] result = '0;
    logic [31:0]         prdata;
    logic                pready, pslverr, power, sample, src_def, src_ext, mux_conv, pa0_ana, pa0_dig;
    logic [4:0]          src_sel;
    logic [2:0]          ext_ch;
    logic [15:0]         seed = 16'h17E0;
    logic [31:0]         v;
    logic                err;
    int                  fails = 0;
    int                  n_tests = 0;
    int                  cyc = 0;
    int                  n;
    logic [4:0]          c;
    logic [9:0]          res;

    always #50 clock = ~clock;

    adc_channel_ctrl #(.TIMEOUT(16)) dut (
        .CLOCK_IN(clock), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .EOC_IN(eoc), .RESULT_IN(result), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CONV_POWER_OUT(power), .CONV_SAMPLE_OUT(sample),
        .SRC_SEL_OUT(src_sel), .SRC_DEFINED_OUT(src_def), .SRC_EXTERNAL_OUT(src_ext),
        .EXT_CHANNEL_OUT(ext_ch), .MUX_TO_CONV_OUT(mux_conv), .PA0_ANALOG_OUT(pa0_ana),
        .PA0_DIGITAL_OUT(pa0_dig));

    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic exp_defined(input logic [4:0] k);
        return !(k == 5'h08 || k == 5'h09 || (k >= 5'h11 && k <= 5'h17));
    endfunction

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic e);
        int k;
        k = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 16);
        chk(k < 16, 1'b1, "apb answer");
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    // ==========================================================
    // timeout
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("unexpected at %0t: run did not finish", $time);
            final_report();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        apb(1'b0, CONV_CTRL_OFS, 32'h0, v, err);
        chk(v, 32'(CONV_CTRL_RST), "control reset");
        apb(1'b0, ABE_OFS, 32'h0, v, err);
        chk(v, 32'(ABE_RST), "block enable reset");
        chk(mux_conv, 1'b1, "mux after reset");
        chk(power, 1'b0, "power after reset");
        $display("test reset done");

        for (int k = 0; k < 32; k++) begin
            c = 5'(k);
            apb(1'b1, CONV_CTRL_OFS, {24'hFFFFFF, 1'b1, c, 2'b00}, v, err);
            apb(1'b0, CONV_CTRL_OFS, 32'h0, v, err);
            chk(v, {25'h0, c, 2'b00}, "select readback");
            settle();
            chk(src_sel, c, "select out");
            chk(src_def, exp_defined(c), "defined");
            chk(src_ext, c >= 5'h18, "external");
            if (c >= 5'h18)
                chk(ext_ch, c[2:0], "channel");
            chk(power, 1'b0, "power off");
        end
        $display("test source select done");

        for (int k = 0; k < 4; k++) begin
            seed = lfsr_next(seed);
            apb(1'b1, ABE_OFS, {24'h0, k[1], seed[5:0], k[0]}, v, err);
            apb(1'b0, ABE_OFS, 32'h0, v, err);
            chk(v, {24'h0, k[1], seed[5:0], k[0]}, "enable readback");
            settle();
            chk(mux_conv, !k[0], "to converter");
            chk(pa0_ana, k[0] & !k[1], "analog on pin");
            chk(pa0_dig, k[1], "digital on pin");
        end
        apb(1'b1, ABE_OFS, 32'h0, v, err);
        $display("test pin routing done");

        for (int k = 0; k < 3; k++) begin
            seed = lfsr_next(seed);
            c = seed[4:0];
            res = seed[15:6];
            result <= res;
            apb(1'b1, CONV_CTRL_OFS, {25'h0, c, 2'b11}, v, err);
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (sample !== 1'b1 && n < 60);
            chk(n >= ACQ_CYCLES && n <= ACQ_CYCLES + 3, 1'b1, "sample delay");
            apb(1'b0, CONV_CTRL_OFS, 32'h0, v, err);
            chk(v, {25'h0, c, 2'b11}, "busy flag");
            chk(power, 1'b1, "power on");
            eoc <= 1'b1;
            repeat (8) @(posedge clock);
            eoc <= 1'b0;
            apb(1'b0, CONV_CTRL_OFS, 32'h0, v, err);
            chk(v, {25'h0, c, 2'b01}, "flag cleared");
            apb(1'b0, RESULT_OFS, 32'h0, v, err);
            chk(v, 32'(res), "result");
        end
        $display("test conversion done");

        apb(1'b1, CONV_CTRL_OFS, 32'h00000003, v, err);
        apb(1'b1, CONV_CTRL_OFS, 32'h00000003, v, err);         // busy: ignored
        repeat (ACQ_CYCLES + 20) @(posedge clock);
        apb(1'b0, CONV_CTRL_OFS, 32'h0, v, err);
        chk(v, 32'h00000001, "flag cleared by timeout");
        $display("test timeout done");

        apb(1'b1, CONV_CTRL_OFS, 32'h00000003, v, err);
        apb(1'b1, CONV_CTRL_OFS, 32'h00000000, v, err);
        apb(1'b0, CONV_CTRL_OFS, 32'h0, v, err);
        chk(v, 32'h0, "abort clears flag");
        apb(1'b1, CONV_CTRL_OFS, 32'h00000002, v, err);
        n = 0;
        repeat (40) begin
            @(posedge clock);
            n += (sample === 1'b1);
        end
        chk(n, 0, "no sample when off");
        apb(1'b0, CONV_CTRL_OFS, 32'h0, v, err);
        chk(v, 32'h0, "flag when off");
        $display("test disabled start done");

        apb(1'b0, 8'h0C, 32'h0, v, err);
        chk(err, 1'b1, "unmapped read error");
        chk(v, 32'h0, "unmapped read data");
        apb(1'b1, RESULT_OFS, 32'h000003FF, v, err);
        chk(err, 1'b1, "result write error");
        apb(1'b0, RESULT_OFS, 32'h0, v, err);
        chk(v, 32'(res), "result unchanged");
        $display("test bus errors done");
        final_report();
    end
endmodule
